// ### logic/cop_pkg.sv
// constants and carrier types for the cache-op permission checker
// assumes a single clock domain and an axi4-lite register master
package cop_pkg;
	// register byte addresses (chosen, no documented offsets)
	localparam logic [7:0] ADDR_MCFG = 8'h00;
	localparam logic [7:0] ADDR_SCFG = 8'h04;
	localparam logic [7:0] ADDR_HCFG = 8'h08;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_STAT = 8'h10;
	localparam logic [7:0] ADDR_INSN = 8'h14;
	localparam logic [7:0] ADDR_ID = 8'h18;
	// envcfg field positions
	localparam int INV_LO = 4;
	localparam int INV_HI = 5;
	localparam int CF_BIT = 6;
	localparam int ZE_BIT = 7;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CFG_MASK = 8'hf0;
	localparam logic [1:0] INV_TRAP = 2'h0;
	localparam logic [1:0] INV_FLUSH = 2'h1;
	localparam logic [1:0] INV_RSVD = 2'h2;
	localparam logic [1:0] INV_INVAL = 2'h3;
	localparam logic [31:0] ID_VALUE = 32'h00c0ffee; // arbitrary value
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// privilege modes
	typedef enum logic [2:0] {
		MODE_M, MODE_S, MODE_U, MODE_VSUP, MODE_VUSR
	} cop_mode_t;
	// operation kinds
	typedef enum logic [2:0] {
		OP_NONE, OP_INVAL, OP_CLEAN, OP_FLUSH, OP_ZERO, OP_PREFETCH
	} cop_op_t;
	// check request
	typedef struct packed {
		logic valid;
		cop_op_t op;
		cop_mode_t mode;
		logic [31:0] insn;
	} cop_req_t;
	// check answer
	typedef struct packed {
		logic valid;
		logic illegal;
		logic virt;
		logic execute;
		logic doFlush;
		logic [31:0] tinst;
		logic trigStore;
		logic resvEvent;
	} cop_rsp_t;
	// trigger attributes offered by the debug logic
	typedef struct packed {
		logic [3:0] trigType;
		logic select;
		logic [3:0] size;
		logic store;
	} cop_trig_t;
endpackage

// ### logic/cop_check.sv
// cache-op permission checker with envcfg registers on axi4-lite
// assumes decode presents one request per cycle, answer one cycle later
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cop_check
	import cop_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic hypEnabled,
	input wire logic zeroTinst,
	input wire cop_req_t req,
	output cop_rsp_t rsp,
	input wire cop_trig_t trig,
	output logic trigMatchOk,
	input wire logic remoteCmoHit,
	input wire cop_op_t remoteOp,
	output logic resvSatisfy,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [7:0] mCfg_r, sCfg_r, hCfg_r;
	logic [7:0] mCfg_nxt, sCfg_nxt, hCfg_nxt;
	logic [7:0] awAddr_r, arAddr_r;
	logic awHeld_r, wHeld_r;
	logic [31:0] wData_r;
	logic [3:0] wStrb_r;
	logic [1:0] bResp_r;
	logic bValid_r, rValid_r;
	logic [31:0] rData_r;
	logic [1:0] rResp_r;
	logic zeroT_r;
	logic [7:0] trapCnt_r, trapCnt_nxt;
	cop_rsp_t rsp_r, rsp_nxt;

	// legalise a write: reserved invalidate code keeps the previous field
	function automatic logic [7:0] legalise(input logic [7:0] old,
		input logic [7:0] wr);
		logic [7:0] v;
		v = wr & CFG_MASK;
		if (v[INV_HI:INV_LO] == INV_RSVD)
			v[INV_HI:INV_LO] = old[INV_HI:INV_LO];
		return v;
	endfunction

	// invalidate field test, used for every register
	function automatic logic invIs(input logic [7:0] c, input logic [1:0] k);
		return c[INV_HI:INV_LO] == k;
	endfunction

	// --- bus write path: address and data taken in either order
	wire doWrite = awHeld_r && wHeld_r && !bValid_r;
	wire wrMapped = awAddr_r == ADDR_MCFG || awAddr_r == ADDR_SCFG ||
		awAddr_r == ADDR_HCFG || awAddr_r == ADDR_CTRL;
	wire wrLow = doWrite && wrMapped && wStrb_r[0];
	assign s_axi_awready = !awHeld_r;
	assign s_axi_wready = !wHeld_r;
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;

	// only the low lane carries config bits, upper lanes are ignored
	assign mCfg_nxt = (wrLow && awAddr_r == ADDR_MCFG) ?
		legalise(mCfg_r, wData_r[7:0]) : mCfg_r;
	assign sCfg_nxt = (wrLow && awAddr_r == ADDR_SCFG) ?
		legalise(sCfg_r, wData_r[7:0]) : sCfg_r;
	// hypervisor register reads zero and drops writes when absent
	assign hCfg_nxt = !hypEnabled ? CFG_RESET :
		(wrLow && awAddr_r == ADDR_HCFG) ?
		legalise(hCfg_r, wData_r[7:0]) : hCfg_r;

	// bus write handshake
	always_ff @(posedge clk) begin
		if (reset) begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h0;
			wStrb_r <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && !awHeld_r) begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHeld_r) begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite) begin
				bValid_r <= 1'b1;
				bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (bValid_r && s_axi_bready) begin
				bValid_r <= 1'b0;
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
			end
		end
	end

	// config registers and control bit
	always_ff @(posedge clk) begin
		if (reset) begin
			mCfg_r <= CFG_RESET;
			sCfg_r <= CFG_RESET;
			hCfg_r <= CFG_RESET;
			zeroT_r <= 1'b0;
		end else begin
			mCfg_r <= mCfg_nxt;
			sCfg_r <= sCfg_nxt;
			hCfg_r <= hCfg_nxt;
			if (wrLow && awAddr_r == ADDR_CTRL)
				zeroT_r <= wData_r[0];
		end
	end

	// --- bus read path
	wire [31:0] rdMux =
		(s_axi_araddr == ADDR_MCFG) ? {24'h0, mCfg_r} :
		(s_axi_araddr == ADDR_SCFG) ? {24'h0, sCfg_r} :
		(s_axi_araddr == ADDR_HCFG) ? {24'h0, hCfg_r} :
		(s_axi_araddr == ADDR_CTRL) ? {31'h0, zeroT_r} :
		(s_axi_araddr == ADDR_STAT) ? {23'h0, hypEnabled, trapCnt_r} :
		(s_axi_araddr == ADDR_INSN) ? rsp_r.tinst :
		(s_axi_araddr == ADDR_ID) ? ID_VALUE : 32'h0;
	wire rdMapped = s_axi_araddr <= ADDR_ID && s_axi_araddr[1:0] == 2'h0;
	assign s_axi_arready = !rValid_r;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;

	// read answer one cycle after address taken
	always_ff @(posedge clk) begin
		if (reset) begin
			rValid_r <= 1'b0;
			rData_r <= 32'h0;
			rResp_r <= RESP_OKAY;
		end else if (s_axi_arvalid && !rValid_r) begin
			rValid_r <= 1'b1;
			rData_r <= rdMapped ? rdMux : 32'h0;
			rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rValid_r && s_axi_rready) begin
			rValid_r <= 1'b0;
		end
	end

	// --- permission decode
	wire isM = req.mode == MODE_M;
	wire isU = req.mode == MODE_U;
	wire isVSup = req.mode == MODE_VSUP;
	wire isVUsr = req.mode == MODE_VUSR;
	// sCfg governs only the user-level modes MODE_U and MODE_VUSR; hCfg reads zero when absent
	wire [7:0] hEff = hypEnabled ? hCfg_r : CFG_RESET;

	wire invIll = (!isM && invIs(mCfg_r, INV_TRAP)) ||
		(isU && invIs(sCfg_r, INV_TRAP));
	wire invVirt = (isVSup && invIs(hEff, INV_TRAP)) ||
		(isVUsr && (invIs(hEff, INV_TRAP) ||
		invIs(sCfg_r, INV_TRAP)));
	// machine mode never reaches a flush term, so it stays a true invalidate
	wire invFl = (!isM && invIs(mCfg_r, INV_FLUSH)) ||
		(isU && invIs(sCfg_r, INV_FLUSH)) ||
		(isVSup && invIs(hEff, INV_FLUSH)) ||
		(isVUsr && (invIs(hEff, INV_FLUSH) ||
		invIs(sCfg_r, INV_FLUSH)));

	wire cfIll = (!isM && !mCfg_r[CF_BIT]) ||
		(isU && !sCfg_r[CF_BIT]);
	wire cfVirt = (isVSup && !hEff[CF_BIT]) ||
		(isVUsr && !(hEff[CF_BIT] && sCfg_r[CF_BIT]));
	wire zIll = (!isM && !mCfg_r[ZE_BIT]) ||
		(isU && !sCfg_r[ZE_BIT]);
	wire zVirt = (isVSup && !hEff[ZE_BIT]) ||
		(isVUsr && !(hEff[ZE_BIT] && sCfg_r[ZE_BIT]));

	logic ill, virt;
	// select by operation; prefetch has no trap path at all
	always_comb begin
		ill = 1'b0;
		virt = 1'b0;
		case (req.op)
			OP_INVAL: begin
				ill = invIll;
				virt = !invIll && invVirt;
			end
			OP_CLEAN, OP_FLUSH: begin
				ill = cfIll;
				virt = !cfIll && cfVirt;
			end
			OP_ZERO: begin
				ill = zIll;
				virt = !zIll && zVirt;
			end
			OP_PREFETCH: begin
				ill = 1'b0;
				virt = 1'b0;
			end
			default: begin
				ill = 1'b0;
				virt = 1'b0;
			end
		endcase
	end

	wire isMgmtZero = req.op == OP_INVAL || req.op == OP_CLEAN ||
		req.op == OP_FLUSH || req.op == OP_ZERO;
	// standard transform: keep operation, funct3 and opcode only
	wire [31:0] tStd = {req.insn[31:20], 5'h00, req.insn[14:12], 5'h00,
		req.insn[6:0]};
	wire trapNow = req.valid && (ill || virt);

	always_comb begin
		rsp_nxt = rsp_r;
		rsp_nxt.valid = req.valid && req.op != OP_NONE;
		rsp_nxt.illegal = req.valid && ill;
		rsp_nxt.virt = req.valid && virt;
		rsp_nxt.execute = rsp_nxt.valid && !ill && !virt;
		rsp_nxt.doFlush = req.valid && req.op == OP_INVAL && !ill &&
			!virt && invFl;
		// stores only for management and zero accesses
		rsp_nxt.trigStore = req.valid && isMgmtZero;
		rsp_nxt.resvEvent = 1'b0;
		if (trapNow)
			rsp_nxt.tinst = (zeroTinst || zeroT_r) ? 32'h0 : tStd;
	end
	assign trapCnt_nxt = trapNow ? trapCnt_r + 8'h01 : trapCnt_r;

	// answer register and trap counter
	always_ff @(posedge clk) begin
		if (reset) begin
			rsp_r <= '0;
			trapCnt_r <= 8'h00;
		end else begin
			rsp_r <= rsp_nxt;
			trapCnt_r <= trapCnt_nxt;
		end
	end
	assign rsp = rsp_r;

	// trigger match permission for cache-op accesses
	assign trigMatchOk = trig.trigType == 4'h6 && !trig.select &&
		trig.size == 4'h0 && trig.store;

	// remote management or zero hit counts as a reservation-loop event
	assign resvSatisfy = remoteCmoHit && remoteOp != OP_PREFETCH &&
		remoteOp != OP_NONE;

	// assertions: each answer is judged one edge after its request
	a_inval_machine: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_INVAL && isM |=>
		rsp.execute && !rsp.doFlush)
		else $error("machine invalidate not true invalidate");
	a_prefetch_notrap: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_PREFETCH |=> !rsp.illegal && !rsp.virt)
		else $error("prefetch trapped");
	a_inv_illegal: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_INVAL && isU &&
		sCfg_r[INV_HI:INV_LO] == 2'h0 |=> rsp.illegal)
		else $error("user invalidate missed illegal");
	a_inv_virt: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_INVAL && isVSup && hypEnabled &&
		mCfg_r[INV_HI:INV_LO] != 2'h0 &&
		hCfg_r[INV_HI:INV_LO] == 2'h0 |=> rsp.virt && !rsp.illegal)
		else $error("guest supervisor invalidate missed virtual trap");
	a_inv_flush: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_INVAL && isU &&
		mCfg_r[INV_HI:INV_LO] == 2'h1 &&
		sCfg_r[INV_HI:INV_LO] == 2'h3 |=> rsp.doFlush)
		else $error("invalidate did not flush");
	a_cf_illegal: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_CLEAN && !isM && !mCfg_r[6] |=>
		rsp.illegal)
		else $error("clean missed illegal");
	a_cf_virt: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_FLUSH && isVUsr && mCfg_r[6] &&
		sCfg_r[6] && !hEff[6] |=> rsp.virt)
		else $error("guest user flush missed virtual trap");
	a_zero_virt: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_ZERO && isVSup && mCfg_r[7] &&
		!hEff[7] |=> rsp.virt && !rsp.execute)
		else $error("guest supervisor zero missed virtual trap");
	a_zero_illegal: assert property (
		@(posedge clk) disable iff (reset)
		req.valid && req.op == OP_ZERO && isU && !sCfg_r[7] |=>
		rsp.illegal)
		else $error("user zero missed illegal");
	a_tinst_form: assert property (
		@(posedge clk) disable iff (reset)
		trapNow && !zeroTinst && !zeroT_r |=>
		rsp.tinst[19:15] == 5'h0 && rsp.tinst[11:7] == 5'h0 &&
		rsp.tinst[31:20] == $past(req.insn[31:20]))
		else $error("bad transformed instruction");
	a_rsvd_kept: assert property (
		@(posedge clk) disable iff (reset)
		wrLow && awAddr_r == ADDR_MCFG && wData_r[5:4] == 2'h2 |=>
		mCfg_r[5:4] == $past(mCfg_r[5:4]))
		else $error("reserved code stored");
	a_hyp_absent: assert property (
		@(posedge clk) disable iff (reset)
		!hypEnabled |=> hCfg_r == 8'h00)
		else $error("absent hyp register held value");
	c_inv_flush: cover property (@(posedge clk) rsp.doFlush);
	c_virt_trap: cover property (@(posedge clk) rsp.virt);
	c_ill_trap: cover property (@(posedge clk) rsp.illegal);
	c_resv: cover property (@(posedge clk) resvSatisfy);
endmodule

// ### test/cop_decode_model.sv
// decode-side model: presents one check request and collects the answer
// assumes the checker answers at the edge after the request is taken
`timescale 1ns/1ps
module cop_decode_model
	import cop_pkg::*;
(
	input wire logic clk,
	output cop_req_t req,
	input wire cop_rsp_t rsp
);
	initial req = '0;

	// request stands for one edge only, so stale requests never repeat
	task automatic issue(input cop_op_t op, input cop_mode_t md,
		input logic [31:0] insn, output cop_rsp_t got);
		@(posedge clk);
		req <= '{valid: 1'b1, op: op, mode: md, insn: insn};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		got = rsp;
	endtask
endmodule

// ### test/tb_cop_check.sv
// self-checking bench for the cache-op permission checker
// assumes one 25 MHz clock and an axi4-lite master driven from here
`timescale 1ns/1ps
module tb_cop_check import cop_pkg::*;;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hypEnabled = 1'b1;
	logic zeroTinst = 1'b0;
	cop_req_t req;
	cop_rsp_t rsp, got;
	cop_trig_t trig = '0;
	logic trigMatchOk, resvSatisfy, s_axi_awready, s_axi_wready;
	logic remoteCmoHit = 1'b0;
	cop_op_t remoteOp = OP_NONE;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, i = 32'h13579bdf;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] e;
	logic [7:0] tc = 8'h00;
	logic [7:0] cfgTab [4] = '{8'h00, 8'h10, 8'hf0, 8'h30};
	int errors = 0;
	int check_count = 0;

	always #20 clk = ~clk;

	cop_check i_dut (.clk(clk), .reset(reset), .hypEnabled(hypEnabled),
		.zeroTinst(zeroTinst), .req(req), .rsp(rsp), .trig(trig),
		.trigMatchOk(trigMatchOk), .remoteCmoHit(remoteCmoHit),
		.remoteOp(remoteOp), .resvSatisfy(resvSatisfy),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready));
	cop_decode_model i_dec (.clk(clk), .req(req), .rsp(rsp));

	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// each channel is released only at the edge that takes it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, exp);
		check("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	// expected {illegal, virtual, execute, flush} worked out per mode
	function automatic logic [3:0] exp_perm(cop_op_t op, cop_mode_t md,
		logic [7:0] m, logic [7:0] s, logic [7:0] h);
		logic eM, eS, eH, nm, u, vSup, vUsr, ill, vi, fl;
		nm = md != MODE_M;
		u = md == MODE_U;
		vSup = md == MODE_VSUP;
		vUsr = md == MODE_VUSR;
		eM = m[CF_BIT];
		eS = s[CF_BIT];
		eH = h[CF_BIT];
		if (op == OP_INVAL) begin
			eM = m[INV_HI:INV_LO] != INV_TRAP;
			eS = s[INV_HI:INV_LO] != INV_TRAP;
			eH = h[INV_HI:INV_LO] != INV_TRAP;
		end else if (op == OP_ZERO) begin
			eM = m[ZE_BIT];
			eS = s[ZE_BIT];
			eH = h[ZE_BIT];
		end
		ill = (nm && !eM) || (u && !eS);
		vi = !ill && ((vSup && !eH) || (vUsr && !(eH && eS)));
		fl = (nm && m[5:4] == INV_FLUSH) || (u && s[5:4] == INV_FLUSH) ||
			(vSup && h[5:4] == INV_FLUSH) ||
			(vUsr && (h[5:4] == INV_FLUSH || s[5:4] == INV_FLUSH));
		if (op == OP_PREFETCH) return 4'b0010;
		return {ill, vi, !ill && !vi, fl && op == OP_INVAL && !ill && !vi};
	endfunction

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// cut a hang short well beyond the expected run of a few thousand edges
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		stop_test();
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		rdchk(ADDR_MCFG, {24'h0, CFG_RESET}, RESP_OKAY);
		rdchk(ADDR_SCFG, {24'h0, CFG_RESET}, RESP_OKAY);
		rdchk(8'h40, 32'h0, RESP_SLVERR);
		wr(ADDR_MCFG, 32'hffffffff);
		rdchk(ADDR_MCFG, 32'hf0, RESP_OKAY);
		wr(ADDR_MCFG, 32'h20);
		rdchk(ADDR_MCFG, 32'h30, RESP_OKAY);
		hypEnabled <= 1'b0;
		wr(ADDR_HCFG, 32'hf0);
		rdchk(ADDR_HCFG, 32'h0, RESP_OKAY);
		hypEnabled <= 1'b1;
		// every mode and every op except OP_NONE against a spread of enable settings
		for (int a = 0; a < 4; a++) for (int b = 0; b < 4; b++)
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_MCFG, {24'h0, cfgTab[a]});
			wr(ADDR_SCFG, {24'h0, cfgTab[b]});
			wr(ADDR_HCFG, {24'h0, cfgTab[c]});
			for (int md = 0; md < 5; md++) for (int op = 1; op < 6; op++) begin
				i = i + 32'h01020305;
				i_dec.issue(cop_op_t'(op), cop_mode_t'(md), i, got);
				e = exp_perm(cop_op_t'(op), cop_mode_t'(md), cfgTab[a],
					cfgTab[b], cfgTab[c]);
				check("valid", {31'h0, got.valid}, 32'h1);
				check("ill", {31'h0, got.illegal},
					{31'h0, e[3]});
				check("virt", {31'h0, got.virt},
					{31'h0, e[2]});
				check("exec", {31'h0, got.execute},
					{31'h0, e[1]});
				check("flush", {31'h0, got.doFlush},
					{31'h0, e[0]});
				check("store", {31'h0, got.trigStore},
					{31'h0, op != 5});
				check("resv", {31'h0, got.resvEvent}, 32'h0);
				if (e[3] | e[2])
					tc = tc + 8'h01;
				if (e[3] | e[2])
					check("tinst", got.tinst, {i[31:20], 5'h0, i[14:12],
						5'h0, i[6:0]});
			end
		end
		wr(ADDR_MCFG, 32'h0);
		zeroTinst <= 1'b1;
		i_dec.issue(OP_ZERO, MODE_U, 32'hffffffff, got);
		check("ztinst", got.tinst, 32'h0);
		// the control bit alone must also force a zero trap value
		zeroTinst <= 1'b0;
		wr(ADDR_CTRL, 32'h1);
		i_dec.issue(OP_ZERO, MODE_U, 32'h12345678, got);
		check("ctinst", got.tinst, 32'h0);
		tc = tc + 8'h02;
		rdchk(ADDR_CTRL, 32'h1, RESP_OKAY);
		rdchk(ADDR_INSN, 32'h0, RESP_OKAY);
		rdchk(ADDR_STAT, {23'h0, 1'b1, tc}, RESP_OKAY);
		rdchk(ADDR_ID, ID_VALUE, RESP_OKAY);
		// only type 6, address select, size 0 and store may match
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			trig <= (k == 0) ? cop_trig_t'{4'h6, 1'b0, 4'h0, 1'b1} :
				(k == 1) ? cop_trig_t'{4'h2, 1'b0, 4'h0, 1'b1} :
				(k == 2) ? cop_trig_t'{4'h6, 1'b1, 4'h0, 1'b1} :
				(k == 3) ? cop_trig_t'{4'h6, 1'b0, 4'h3, 1'b1} :
				cop_trig_t'{4'h6, 1'b0, 4'h0, 1'b0};
			#1;
			check("trig", {31'h0, trigMatchOk},
				{31'h0, k == 0});
		end
		// remote management and zero count, prefetch and idle do not
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			remoteCmoHit <= 1'b1;
			remoteOp <= cop_op_t'(k);
			#1;
			check("resv", {31'h0, resvSatisfy},
				{31'h0, k >= 1 && k <= 4});
		end
		stop_test();
	end
endmodule
